/* design/cps_pkg.sv */
// package: register map, reset values and timing for the preset speed selector
package cps_pkg;
  // clock and timing
  localparam int unsigned CLK_FREQ_MHZ      = 125;
  localparam int unsigned RAMP_UNIT_US      = 1000;   // ramp times are counted in ms
  localparam int unsigned CYC_PER_RAMP_UNIT = RAMP_UNIT_US * CLK_FREQ_MHZ;
  localparam int unsigned SEL_LATENCY_US    = 2000;   // longest select reaction time
  localparam int unsigned SEL_LATENCY_CYC   = SEL_LATENCY_US * CLK_FREQ_MHZ;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SPD1   = 8'h04;
  localparam logic [7:0] OFS_SPD2   = 8'h08;
  localparam logic [7:0] OFS_SPD3   = 8'h0C;
  localparam logic [7:0] OFS_ACCEL  = 8'h10;
  localparam logic [7:0] OFS_DECEL  = 8'h14;
  localparam logic [7:0] OFS_MOTMAX = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // control register fields
  localparam int CTRL_METHOD_LSB = 0;    // 4 bits
  localparam int CTRL_ALLOC_LSB  = 4;    // 4 bits
  localparam int CTRL_MAPDIR_BIT = 8;
  localparam int CTRL_MAPA_BIT   = 9;
  localparam int CTRL_MAPB_BIT   = 10;

  // status register fields
  localparam int STAT_REF_LSB    = 0;    // 16 bits signed
  localparam int STAT_SRC_LSB    = 16;   // 3 bits
  localparam int STAT_PRESET_BIT = 19;
  localparam int STAT_FWDLIM_BIT = 20;
  localparam int STAT_REVLIM_BIT = 21;
  localparam int STAT_PION_BIT   = 22;
  localparam int STAT_PBLOCK_BIT = 23;
  localparam int STAT_CONT_LSB   = 24;   // 3 bits: dir, a, b

  // parameter limits and reset values
  localparam logic [13:0] SPEED_MIN     = 14'h0001;
  localparam logic [13:0] SPEED_MAX     = 14'h2710;  // 10000
  localparam logic [13:0] SPD1_RST      = 14'h0064;  // 100
  localparam logic [13:0] SPD2_RST      = 14'h00C8;  // 200
  localparam logic [13:0] SPD3_RST      = 14'h012C;  // 300
  localparam logic [13:0] RAMP_RST      = 14'h0000;
  localparam logic [13:0] MOTMAX_RST    = 14'h0BB8;  // 3000
  localparam logic [3:0]  METHOD_RST    = 4'h0;
  localparam logic [3:0]  ALLOC_RST     = 4'h0;
  localparam logic [3:0]  METHOD_STOP   = 4'h3;
  localparam logic [3:0]  METHOD_ASPEED = 4'h4;
  localparam logic [3:0]  METHOD_PULSE  = 4'h5;
  localparam logic [3:0]  METHOD_ATORQ  = 4'h6;

  // reference source chosen for the motor
  typedef enum logic [2:0] {
    SRC_NORMAL, SRC_ZERO, SRC_PRESET, SRC_ASPEED, SRC_PULSE, SRC_ATORQ
  } cps_src_t;
endpackage : cps_pkg

/* design/cps_sync.sv */
// two-stage synchroniser for the contact pins
`timescale 1ns/1ps
`default_nettype none
module cps_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstN,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cps_sync_t;

  cps_sync_t cur_ff;
  cps_sync_t nxt_ff;

  // first stage feeds only the second
  always_comb begin
    nxt_ff        = cur_ff;
    nxt_ff.stage1 = pinIn;
    nxt_ff.stage2 = cur_ff.stage1;
  end

  // pins idle high, so reset to all ones
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cur_ff <= '1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign syncOut = cur_ff.stage2;
endmodule : cps_sync
`default_nettype wire

/* design/cps_ramp.sv */
// soft start ramp of the internal speed reference
`timescale 1ns/1ps
`default_nettype none
module cps_ramp
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstN,
  // target and settings
  input  wire logic signed [15:0] target,
  input  wire logic        [13:0] accelTime,
  input  wire logic        [13:0] decelTime,
  input  wire logic        [13:0] maxSpeed,
  input  wire logic               rampEn,
  // ramped reference
  output logic signed      [15:0] speedRef
);
  typedef struct packed {
    logic signed [15:0] spd;
    logic        [31:0] acc;
  } cps_ramp_t;

  cps_ramp_t   cur_ff;
  cps_ramp_t   nxt_ff;
  logic        goUp;
  logic        accelPhase;
  logic [13:0] timeSel;
  logic [31:0] thr;
  logic [31:0] accSum;

  // speed rises per clock by maxSpeed/(time*cycles per ms), kept exact by an accumulator
  always_comb begin
    nxt_ff     = cur_ff;
    goUp       = target > cur_ff.spd;
    accelPhase = goUp ? (cur_ff.spd >= 0) : (cur_ff.spd <= 0);
    timeSel    = accelPhase ? accelTime : decelTime;
    thr        = 32'(timeSel) * 32'(CYC_PER_RAMP_UNIT);
    accSum     = cur_ff.acc + 32'(maxSpeed);
    if (target == cur_ff.spd) begin
      nxt_ff.acc = '0;
    end else if (!rampEn || timeSel == '0) begin
      nxt_ff.spd = target;
      nxt_ff.acc = '0;
    end else if (accSum >= thr) begin
      nxt_ff.acc = accSum - thr;
      nxt_ff.spd = goUp ? 16'(cur_ff.spd + 16'sd1) : 16'(cur_ff.spd - 16'sd1);
    end else begin
      nxt_ff.acc = accSum;
    end
  end

  // ramp state
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign speedRef = cur_ff.spd;
endmodule : cps_ramp
`default_nettype wire

/* design/cps_top.sv */
// preset speed selector: contact decode, mode select, ramp and APB registers
// Behaviour
// - selection active only for methods 3 to 6
// - decode select pair into speed one, two, three
// - both off: method picks zero, analog, pulse, torque
// - direction input off forward, on reverse
// - contacts active low, logic zero means on
// - three speeds 1..10000 rpm, reset 100/200/300
// - clamp preset speed to motor maximum
// - acceleration time ramps standstill to maximum
// - deceleration time ramps maximum to standstill
// - zero times mean no ramping
// - unused selection: selects are torque limits
// - unused selection: direction input does PI switching
// - selection needs all three inputs allocated
// - allocation setting zero maps inputs automatically
// - position alternative accepts pulse references only
// - ramp only with method 5 presets
// - block pulses after preset until positioning completed
// - react to select change within 2 ms
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module cps_top
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // contact pins, low means on
  input  wire logic               directionOrPiInputN,
  input  wire logic               fwdLimitOrSelectAInputN,
  input  wire logic               revLimitOrSelectBInputN,
  // position loop
  input  wire logic               positioningCompleted,
  // motor reference outputs
  output logic signed [15:0]      speedRef,
  output cps_pkg::cps_src_t       refSource,
  output logic                    presetActive,
  output logic                    fwdTorqueLimitOn,
  output logic                    revTorqueLimitOn,
  output logic                    piControlOn,
  output logic                    pulseRefEnable
);
  import cps_pkg::*;

  typedef struct packed {
    logic [3:0]         method;
    logic [3:0]         alloc;
    logic               mapDir;
    logic               mapA;
    logic               mapB;
    logic [13:0]        spd1;
    logic [13:0]        spd2;
    logic [13:0]        spd3;
    logic [13:0]        accel;
    logic [13:0]        decel;
    logic [13:0]        motMax;
    logic [31:0]        rdata;
    logic               slvErr;
    cps_src_t           src;
    logic signed [15:0] target;
    logic               presetOn;
    logic               fwdLim;
    logic               revLim;
    logic               piOn;
    logic               pulseBlock;
    logic               rampEn;
  } cps_state_t;

  // methods in which contacts may select presets
  function automatic logic isPresetMethod(input logic [3:0] m);
    isPresetMethod = (m >= METHOD_STOP) && (m <= METHOD_ATORQ);
  endfunction : isPresetMethod

  // keep a written speed inside 1..10000 or 0..10000
  function automatic logic [13:0] fitSetting(input logic [31:0] v, input logic [13:0] lo);
    if (v > 32'(SPEED_MAX)) begin
      fitSetting = SPEED_MAX;
    end else if (v < 32'(lo)) begin
      fitSetting = lo;
    end else begin
      fitSetting = v[13:0];
    end
  endfunction : fitSetting

  logic [1:0]          rstSync_ff;
  logic                rstN;
  logic [2:0]          pinSync;
  logic                dirOn;
  logic                selAOn;
  logic                selBOn;
  logic                allocated;
  logic                presetNow;
  logic [13:0]         selSpeed;
  logic [13:0]         limSpeed;
  logic                setupRd;
  logic                accessWr;
  logic                addrOk;
  logic [31:0]         statusWord;
  logic signed [15:0]  rampRef;
  cps_src_t            srcNow;
  cps_state_t          cur_ff;
  cps_state_t          nxt_ff;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // contact pins into the clock domain
  cps_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstN    (rstN),
    .pinIn   ({directionOrPiInputN, fwdLimitOrSelectAInputN, revLimitOrSelectBInputN}),
    .syncOut (pinSync)
  );

  // low level on a line means contact on
  assign dirOn  = ~pinSync[2];
  assign selAOn = ~pinSync[1];
  assign selBOn = ~pinSync[0];

  // automatic or explicit allocation of the three functions
  always_comb begin
    if (cur_ff.alloc == ALLOC_RST) begin
      allocated = isPresetMethod(cur_ff.method);
    end else begin
      allocated = cur_ff.mapDir && cur_ff.mapA && cur_ff.mapB;
    end
  end
  assign presetNow = isPresetMethod(cur_ff.method) && allocated;

  // select pair decode and clamp to the motor maximum
  always_comb begin
    selSpeed = '0;
    srcNow   = SRC_NORMAL;
    if (presetNow) begin
      if (selAOn || selBOn) begin
        srcNow = SRC_PRESET;
        if (!selAOn) begin
          selSpeed = cur_ff.spd1;
        end else if (selBOn) begin
          selSpeed = cur_ff.spd2;
        end else begin
          selSpeed = cur_ff.spd3;
        end
      end else begin
        case (cur_ff.method)
          METHOD_STOP:   srcNow = SRC_ZERO;
          METHOD_ASPEED: srcNow = SRC_ASPEED;
          METHOD_PULSE:  srcNow = SRC_PULSE;
          default:       srcNow = SRC_ATORQ;
        endcase
      end
    end
  end
  assign limSpeed = (selSpeed > cur_ff.motMax) ? cur_ff.motMax : selSpeed;

  // status word seen by software
  always_comb begin
    statusWord                                  = '0;
    statusWord[STAT_REF_LSB +: 16]              = speedRef;
    statusWord[STAT_SRC_LSB +: 3]               = cur_ff.src;
    statusWord[STAT_PRESET_BIT]                 = cur_ff.presetOn;
    statusWord[STAT_FWDLIM_BIT]                 = cur_ff.fwdLim;
    statusWord[STAT_REVLIM_BIT]                 = cur_ff.revLim;
    statusWord[STAT_PION_BIT]                   = cur_ff.piOn;
    statusWord[STAT_PBLOCK_BIT]                 = cur_ff.pulseBlock;
    statusWord[STAT_CONT_LSB +: 3]              = {dirOn, selAOn, selBOn};
  end

  // apb phase decode
  assign setupRd  = psel && !penable && !pwrite;
  assign accessWr = psel && penable && pwrite;
  assign addrOk   = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATUS);

  // next state: registers, selection and pulse gate
  always_comb begin
    nxt_ff = cur_ff;
    // register writes take effect at the access edge
    if (accessWr) begin
      if (paddr == OFS_CTRL) begin
        nxt_ff.method = pwdata[CTRL_METHOD_LSB +: 4];
        nxt_ff.alloc  = pwdata[CTRL_ALLOC_LSB +: 4];
        nxt_ff.mapDir = pwdata[CTRL_MAPDIR_BIT];
        nxt_ff.mapA   = pwdata[CTRL_MAPA_BIT];
        nxt_ff.mapB   = pwdata[CTRL_MAPB_BIT];
      end else if (paddr == OFS_SPD1) begin
        nxt_ff.spd1 = fitSetting(pwdata, SPEED_MIN);
      end else if (paddr == OFS_SPD2) begin
        nxt_ff.spd2 = fitSetting(pwdata, SPEED_MIN);
      end else if (paddr == OFS_SPD3) begin
        nxt_ff.spd3 = fitSetting(pwdata, SPEED_MIN);
      end else if (paddr == OFS_ACCEL) begin
        nxt_ff.accel = fitSetting(pwdata, RAMP_RST);
      end else if (paddr == OFS_DECEL) begin
        nxt_ff.decel = fitSetting(pwdata, RAMP_RST);
      end else if (paddr == OFS_MOTMAX) begin
        nxt_ff.motMax = fitSetting(pwdata, SPEED_MIN);
      end
    end
    // read data captured in the setup cycle
    if (setupRd) begin
      if (paddr == OFS_CTRL) begin
        nxt_ff.rdata = {21'h0, cur_ff.mapB, cur_ff.mapA, cur_ff.mapDir,
                        cur_ff.alloc, cur_ff.method};
      end else if (paddr == OFS_SPD1) begin
        nxt_ff.rdata = {18'h0, cur_ff.spd1};
      end else if (paddr == OFS_SPD2) begin
        nxt_ff.rdata = {18'h0, cur_ff.spd2};
      end else if (paddr == OFS_SPD3) begin
        nxt_ff.rdata = {18'h0, cur_ff.spd3};
      end else if (paddr == OFS_ACCEL) begin
        nxt_ff.rdata = {18'h0, cur_ff.accel};
      end else if (paddr == OFS_DECEL) begin
        nxt_ff.rdata = {18'h0, cur_ff.decel};
      end else if (paddr == OFS_MOTMAX) begin
        nxt_ff.rdata = {18'h0, cur_ff.motMax};
      end else if (paddr == OFS_STATUS) begin
        nxt_ff.rdata = statusWord;
      end else begin
        nxt_ff.rdata = '0;
      end
    end
    if (psel && !penable) begin
      nxt_ff.slvErr = !addrOk;
    end
    // selection outcome, evaluated every clock
    nxt_ff.src      = srcNow;
    nxt_ff.presetOn = presetNow;
    if (srcNow == SRC_PRESET) begin
      nxt_ff.target = dirOn ? -$signed({2'b00, limSpeed})
                            : $signed({2'b00, limSpeed});
    end else begin
      nxt_ff.target = '0;
    end
    nxt_ff.rampEn = presetNow && (cur_ff.method == METHOD_PULSE)
                    && (srcNow == SRC_PRESET);
    // alternative duties when presets are not in use
    nxt_ff.fwdLim = !presetNow && selAOn;
    nxt_ff.revLim = !presetNow && selBOn;
    nxt_ff.piOn   = !presetNow && dirOn;
    // leaving a running preset for pulses waits for positioning completed
    if (srcNow != SRC_PULSE) begin
      nxt_ff.pulseBlock = 1'b0;
    end else if (cur_ff.src == SRC_PRESET && speedRef != 16'sh0000) begin
      nxt_ff.pulseBlock = 1'b1;
    end else if (positioningCompleted) begin
      nxt_ff.pulseBlock = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      cur_ff            <= '0;
      cur_ff.method     <= METHOD_RST;
      cur_ff.alloc      <= ALLOC_RST;
      cur_ff.spd1       <= SPD1_RST;
      cur_ff.spd2       <= SPD2_RST;
      cur_ff.spd3       <= SPD3_RST;
      cur_ff.accel      <= RAMP_RST;
      cur_ff.decel      <= RAMP_RST;
      cur_ff.motMax     <= MOTMAX_RST;
      cur_ff.src        <= SRC_NORMAL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // soft start ramp of the preset reference
  cps_ramp u_ramp (
    .sys_clk   (sys_clk),
    .rstN      (rstN),
    .target    (cur_ff.target),
    .accelTime (cur_ff.accel),
    .decelTime (cur_ff.decel),
    .maxSpeed  (cur_ff.motMax),
    .rampEn    (cur_ff.rampEn),
    .speedRef  (rampRef)
  );

  // outputs
  assign speedRef         = rampRef;
  assign refSource        = cur_ff.src;
  assign presetActive     = cur_ff.presetOn;
  assign fwdTorqueLimitOn = cur_ff.fwdLim;
  assign revTorqueLimitOn = cur_ff.revLim;
  assign piControlOn      = cur_ff.piOn;
  assign pulseRefEnable   = (cur_ff.src == SRC_PULSE) && !cur_ff.pulseBlock;
  assign prdata           = cur_ff.rdata;
  assign pready           = 1'b1;  // zero wait states
  assign pslverr          = psel && penable && cur_ff.slvErr;
endmodule : cps_top
`default_nettype wire

/* test/cps_top_checker.sv */
// assertion checker for the preset speed selector ports
`timescale 1ns/1ps
`default_nettype none
module cps_top_checker
  import cps_pkg::*;
(
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               resetn,
  // contacts and position loop
  input wire logic               directionOrPiInputN,
  input wire logic               fwdLimitOrSelectAInputN,
  input wire logic               revLimitOrSelectBInputN,
  input wire logic               positioningCompleted,
  // reference outputs
  input wire logic signed [15:0] speedRef,
  input wire cps_pkg::cps_src_t  refSource,
  input wire logic               presetActive,
  input wire logic               fwdTorqueLimitOn,
  input wire logic               revTorqueLimitOn,
  input wire logic               piControlOn,
  input wire logic               pulseRefEnable
);
  logic [2:0] upCnt_ff;
  logic       upOk;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // edges since release, so the internal reset copy has let go
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      upCnt_ff <= 3'h0;
    else if (upCnt_ff != 3'h7)
      upCnt_ff <= upCnt_ff + 3'h1;
  end
  assign upOk = (upCnt_ff == 3'h7);
  // contact duties and selection
  a_fwd_limit_map: assert property (
    (upOk && !presetActive && $stable(fwdLimitOrSelectAInputN))[*5]
    |-> fwdTorqueLimitOn == !fwdLimitOrSelectAInputN) else $error("forward limit wrong");
  a_rev_limit_map: assert property (
    (upOk && !presetActive && $stable(revLimitOrSelectBInputN))[*5]
    |-> revTorqueLimitOn == !revLimitOrSelectBInputN) else $error("reverse limit wrong");
  a_pi_switch_map: assert property (
    (upOk && !presetActive && $stable(directionOrPiInputN))[*5]
    |-> piControlOn == !directionOrPiInputN) else $error("pi switch wrong");
  a_preset_flags_off: assert property (
    presetActive[*2] |-> !(fwdTorqueLimitOn || revTorqueLimitOn || piControlOn))
    else $error("limit flags set in preset mode");
  a_select_decode: assert property (
    (upOk && presetActive && $stable({fwdLimitOrSelectAInputN, revLimitOrSelectBInputN})
     && !(fwdLimitOrSelectAInputN && revLimitOrSelectBInputN))[*5]
    |-> refSource == SRC_PRESET) else $error("preset not selected");
  a_zero_stop: assert property (
    (refSource == SRC_ZERO)[*2] |-> speedRef == 16'sh0000) else $error("zero source moves");
  a_no_preset_ref: assert property (
    (!presetActive)[*2] |-> speedRef == 16'sh0000) else $error("reference without preset");
  // pulse gate after a running preset
  a_pulse_hold: assert property (
    refSource == SRC_PULSE && !pulseRefEnable && !positioningCompleted
    |=> refSource != SRC_PULSE || !pulseRefEnable) else $error("pulse gate opened early");
  a_pulse_release: assert property (
    refSource == SRC_PULSE && positioningCompleted
    |=> refSource != SRC_PULSE || pulseRefEnable) else $error("pulse gate stuck");
  a_pulse_source: assert property (
    pulseRefEnable |-> refSource == SRC_PULSE) else $error("pulses outside pulse mode");
  // main scenarios reached
  c_reverse: cover property (refSource == SRC_PRESET && speedRef < 16'sh0000);
  c_blocked: cover property (refSource == SRC_PULSE && !pulseRefEnable);
  c_limits: cover property (fwdTorqueLimitOn && piControlOn);
endmodule : cps_top_checker

bind cps_top cps_top_checker uChecker (
  .sys_clk(sys_clk), .resetn(resetn), .directionOrPiInputN(directionOrPiInputN),
  .fwdLimitOrSelectAInputN(fwdLimitOrSelectAInputN),
  .revLimitOrSelectBInputN(revLimitOrSelectBInputN),
  .positioningCompleted(positioningCompleted), .speedRef(speedRef), .refSource(refSource),
  .presetActive(presetActive), .fwdTorqueLimitOn(fwdTorqueLimitOn),
  .revTorqueLimitOn(revTorqueLimitOn), .piControlOn(piControlOn),
  .pulseRefEnable(pulseRefEnable)
);
`default_nettype wire

/* test/cps_contact_host.sv */
// model of the host controller and switch contacts on the sequence inputs
`timescale 1ns/1ps
`default_nettype none
module cps_contact_host #(
  parameter int SETTLE_CYC = 20
) (
  // clock
  input  wire logic sys_clk,
  // requested contact states, high means closed
  input  wire logic dirOn,
  input  wire logic aOn,
  input  wire logic bOn,
  input  wire logic settleReq,
  // pins towards the device
  output logic      directionOrPiInputN,
  output logic      fwdLimitOrSelectAInputN,
  output logic      revLimitOrSelectBInputN,
  output logic      positioningCompleted
);
  logic [7:0] settleCnt_ff;
  // a closed contact pulls its line low
  assign directionOrPiInputN     = ~dirOn;
  assign fwdLimitOrSelectAInputN = ~aOn;
  assign revLimitOrSelectBInputN = ~bOn;
  // the load reports done only after its settle time
  always_ff @(posedge sys_clk) begin
    if (!settleReq)
      settleCnt_ff <= 8'h00;
    else if (settleCnt_ff != 8'hFF)
      settleCnt_ff <= settleCnt_ff + 8'h01;
  end
  assign positioningCompleted = settleReq && (settleCnt_ff >= 8'(SETTLE_CYC));
endmodule : cps_contact_host
`default_nettype wire

/* test/testbench.sv */
// self-checking testbench for the preset speed selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cps_pkg::*;
  logic               sys_clk, resetn, psel, penable, pwrite, pready, pslverr, rdErr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               dirOn, aOn, bOn, settleReq, dirN, aN, bN, posDone;
  logic signed [15:0] speedRef;
  cps_src_t           refSource;
  logic               presetActive, fwdLim, revLim, piOn, pulseEn;
  int                 failures, samplesChecked, i;
  localparam logic [7:0]  OFS_TAB [6] = '{OFS_SPD1, OFS_SPD2, OFS_SPD3, OFS_ACCEL,
                                          OFS_DECEL, OFS_MOTMAX};
  localparam logic [31:0] RST_TAB [6] = '{32'h64, 32'hC8, 32'h12C, 32'h0, 32'h0, 32'hBB8};
  localparam cps_src_t    SRC_TAB [4] = '{SRC_ZERO, SRC_ASPEED, SRC_PULSE, SRC_ATORQ};
  localparam logic [4:0]  DIR_TAB = 5'h18;
  localparam logic [4:0]  A_TAB   = 5'h0E;
  localparam logic [4:0]  B_TAB   = 5'h03;
  localparam int          SPD_TAB [5] = '{100, 200, 300, -300, 0};
  // clock
  always #4 sys_clk = ~sys_clk;
  // design and far side
  cps_top DUT (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .directionOrPiInputN(dirN), .fwdLimitOrSelectAInputN(aN), .revLimitOrSelectBInputN(bN),
    .positioningCompleted(posDone), .speedRef(speedRef), .refSource(refSource),
    .presetActive(presetActive), .fwdTorqueLimitOn(fwdLim), .revTorqueLimitOn(revLim),
    .piControlOn(piOn), .pulseRefEnable(pulseEn));
  cps_contact_host #(.SETTLE_CYC(20)) uHost (
    .sys_clk(sys_clk), .dirOn(dirOn), .aOn(aOn), .bOn(bOn), .settleReq(settleReq),
    .directionOrPiInputN(dirN), .fwdLimitOrSelectAInputN(aN),
    .revLimitOrSelectBInputN(bN), .positioningCompleted(posDone));
  // verdict and end of run
  task automatic print_verdict();
    if (failures == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic time_out();
    failures++;
    print_verdict();
  endtask : time_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
      time_out();
    rd = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    apb_xfer(1'b0, a, 32'h0);
  endtask : rdreg
  task automatic pins(input logic d, input logic a, input logic b);
    @(posedge sys_clk);
    dirOn <= d;
    aOn   <= a;
    bOn   <= b;
  endtask : pins
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask : settle
  // wait for the reference to reach a value, then compare it
  task automatic wait_speed(input int exp, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      @(posedge sys_clk);
      if (speedRef === 16'(exp))
        break;
    end
    if (n == bound)
      time_out();
    check(32'(speedRef), 32'(exp));
  endtask : wait_speed
  // main sequence
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {dirOn, aOn, bOn, settleReq} = 4'h0;
    failures = 0;
    samplesChecked = 0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // defaults, clamping and an unmapped address
    for (i = 0; i < 6; i++) begin
      rdreg(OFS_TAB[i]);
      check(rd, RST_TAB[i]);
    end
    wr(OFS_SPD1, 32'h0);
    rdreg(OFS_SPD1);
    check(rd, 32'h1);
    wr(OFS_SPD1, 32'h4E20);
    rdreg(OFS_SPD1);
    check(rd, 32'h2710);
    wr(OFS_SPD1, 32'h64);
    rdreg(8'h20);
    check(rd, 32'h0);
    check({31'h0, rdErr}, 32'h1);
    // selection only for the four contact methods
    for (i = 0; i < 14; i++) begin
      wr(OFS_CTRL, 32'(i));
      settle();
      check({31'h0, presetActive}, {31'h0, i inside {[3:6]}});
    end
    wr(OFS_CTRL, 32'h313);
    settle();
    check({31'h0, presetActive}, 32'h0);
    wr(OFS_CTRL, 32'h713);
    settle();
    check({31'h0, presetActive}, 32'h1);
    rdreg(OFS_CTRL);
    check(rd, 32'h713);
    // decode, direction and the motor limit, no ramp
    wr(OFS_CTRL, 32'h3);
    for (i = 0; i < 5; i++) begin
      pins(DIR_TAB[i], A_TAB[i], B_TAB[i]);
      wait_speed(SPD_TAB[i], 12);
    end
    wr(OFS_MOTMAX, 32'hFA);
    pins(1'b1, 1'b1, 1'b0);
    wait_speed(-250, 12);
    wr(OFS_MOTMAX, 32'h2710);
    pins(1'b0, 1'b0, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'(i + 3));
      settle();
      check(32'(refSource), 32'(SRC_TAB[i]));
    end
    // contacts as torque limits and pi switch
    wr(OFS_CTRL, 32'h0);
    pins(1'b1, 1'b1, 1'b0);
    settle();
    check({29'h0, fwdLim, revLim, piOn}, 32'h5);
    pins(1'b0, 1'b0, 1'b1);
    settle();
    check({29'h0, fwdLim, revLim, piOn}, 32'h2);
    rdreg(OFS_STATUS);
    check(rd, 32'h01200000);
    // pulses stay shut after a running preset until positioning is done
    wr(OFS_CTRL, 32'h5);
    wait_speed(100, 12);
    pins(1'b0, 1'b0, 1'b0);
    settle();
    check({28'h0, refSource, pulseEn}, {28'h0, SRC_PULSE, 1'b0});
    settleReq <= 1'b1;
    for (i = 0; i < 40 && pulseEn !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 40)
      time_out();
    check({31'h0, pulseEn}, 32'h1);
    settleReq <= 1'b0;
    // method 5 presets ramp up and down
    wr(OFS_ACCEL, 32'h1);
    wr(OFS_DECEL, 32'h1);
    pins(1'b0, 1'b0, 1'b1);
    repeat (32) @(posedge sys_clk);
    check({31'h0, speedRef > 16'sh0 && speedRef < 16'sh64}, 32'h1);
    wait_speed(100, 3000);
    pins(1'b0, 1'b1, 1'b1);
    wait_speed(200, 3000);
    pins(1'b0, 1'b0, 1'b1);
    repeat (32) @(posedge sys_clk);
    check({31'h0, speedRef > 16'sh64 && speedRef < 16'shC8}, 32'h1);
    wait_speed(100, 3000);
    // method 4 steps at once despite the ramp times
    wr(OFS_CTRL, 32'h4);
    pins(1'b0, 1'b1, 1'b1);
    wait_speed(200, 12);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
